// ==== rtl/spd_pkg.sv ====
// Constants, types and field layouts for the serial diagnosis command port.
// Assumes a single system clock; serial pins are sampled, never used as clocks.
package spd_pkg;
	localparam int CH = 4;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_WRAP = 5'h17;
	localparam logic [15:0] DIAG_RESET = 16'h5800;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] DIAG_TAIL = 2'h1;
	localparam logic [1:0] READ_ANS = 2'h2;
	localparam logic [1:0] MODE_IDLE = 2'h3;
	localparam logic [1:0] MODE_ACTIVE = 2'h2;
	localparam logic [3:0] A0_OUT = 4'h0;
	localparam logic [3:0] A0_MAP = 4'h1;
	localparam logic [3:0] A0_DIAGCFG = 4'h2;
	localparam logic [3:0] A0_OSM = 4'h3;
	localparam logic [3:0] A0_RST = 4'h4;
	localparam logic [1:0] A1_ZERO = 2'h0;
	localparam logic [1:0] A1_MAP1 = 2'h1;
	localparam logic [3:0] OUT_RST = 4'h0;
	localparam logic [3:0] MAP0_RST = 4'h4;
	localparam logic [3:0] MAP1_RST = 4'h8;
	localparam int OPENLOAD_GLOBAL_DISABLE_BIT = 4;
	localparam int RST_BIT = 0;
	localparam int FAULT_UV_BIT = 4;
	// Pin vector {vds_low, in, sleep_n, sdi, sclk, select_n}
	localparam logic [9:0] PIN_RST = 10'h009;
	localparam logic [3:0] AXI_STATUS = 4'h0;
	localparam logic [3:0] AXI_FAULT = 4'h4;
	localparam logic [3:0] AXI_LAST = 4'h8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] cmd;
		logic [3:0] primary_addr_field;
		logic [1:0] secondary_addr_field;
		logic [7:0] data;
	} spd_frame_s;

	typedef struct packed {
		logic z15;
		logic supply_undervolt_flag;
		logic z13;
		logic [1:0] mode;
		logic frame_error_flag;
		logic z9;
		logic off_openload_flag;
		logic [3:0] z7;
		logic [3:0] channel_fault_flag;
	} spd_diag_s;

	typedef enum logic {RESP_DIAG, RESP_REG} spd_resp_e;
	typedef enum logic {LINK_IDLE, LINK_XFER} spd_link_e;
endpackage

// ==== rtl/spd_port.sv ====
// Serial diagnosis command port of a four channel low side driver, with AXI4-Lite
// access for the analog stand-ins (fault flags, undervoltage) and state readback.
// Assumes serial pins are asynchronous to sys_clk and at least 4x slower.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spd_port (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic select_low_pin, // Serial select, low active
	input wire logic sclk_pin, // Serial clock
	input wire logic sdi_pin, // Serial data in
	output logic sdo_out, // Serial data out level
	output logic sdo_oe, // Serial data out enable
	input wire logic sleep_n_pin, // Sleep request, low active
	input wire logic [spd_pkg::CH-1:0] vds_low_pin, // Drain voltage below threshold
	input wire logic [1:0] in_pin, // Parallel input pins
	output logic [spd_pkg::CH-1:0] out_on, // Channel switch drive
	output logic [spd_pkg::CH-1:0] openload_current_enable, // Diagnosis current on
	input wire logic [3:0] s_axi_awaddr, // AXI write address
	input wire logic s_axi_awvalid, // AXI write address valid
	output logic s_axi_awready, // AXI write address ready
	input wire logic [31:0] s_axi_wdata, // AXI write data
	input wire logic [3:0] s_axi_wstrb, // AXI write strobes
	input wire logic s_axi_wvalid, // AXI write data valid
	output logic s_axi_wready, // AXI write data ready
	output logic [1:0] s_axi_bresp, // AXI write response
	output logic s_axi_bvalid, // AXI write response valid
	input wire logic s_axi_bready, // AXI write response ready
	input wire logic [3:0] s_axi_araddr, // AXI read address
	input wire logic s_axi_arvalid, // AXI read address valid
	output logic s_axi_arready, // AXI read address ready
	output logic [31:0] s_axi_rdata, // AXI read data
	output logic [1:0] s_axi_rresp, // AXI read response
	output logic s_axi_rvalid, // AXI read valid
	input wire logic s_axi_rready // AXI read ready
);
	import spd_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [9:0] pin_meta;
	logic [9:0] pin_sync;
	logic csn_d;
	logic sclk_d;
	logic csn_s;
	logic sclk_s;
	logic sdi_s;
	logic sleep_n_s;
	logic [1:0] in_s;
	logic [CH-1:0] vds_s;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta <= PIN_RST;
			pin_sync <= PIN_RST;
		end else begin
			pin_meta <= {vds_low_pin, in_pin, sleep_n_pin, sdi_pin, sclk_pin, select_low_pin};
			pin_sync <= pin_meta;
		end
	end

	assign csn_s = pin_sync[0];
	assign sclk_s = pin_sync[1];
	assign sdi_s = pin_sync[2];
	assign sleep_n_s = pin_sync[3];
	assign in_s = pin_sync[5:4];
	assign vds_s = pin_sync[9:6];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			csn_d <= 1'b1;
			sclk_d <= 1'b0;
		end else begin
			csn_d <= csn_s;
			sclk_d <= sclk_s;
		end
	end

	// ****************************************
	// Link state and edges
	// ****************************************
	spd_link_e link;
	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	logic sck_rise;

	assign cs_fall = csn_d & ~csn_s;
	assign cs_rise = ~csn_d & csn_s & (link == LINK_XFER);
	// Serial clock only counts inside an access
	assign sck_fall = sclk_d & ~sclk_s & ~csn_s & (link == LINK_XFER);
	assign sck_rise = ~sclk_d & sclk_s & ~csn_s & (link == LINK_XFER);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link <= LINK_IDLE;
		end else begin
			case (link)
				LINK_IDLE: begin
					if (cs_fall && sleep_n_s) begin
						link <= LINK_XFER;
					end
				end
				LINK_XFER: begin
					if (csn_s || !sleep_n_s) begin
						link <= LINK_IDLE;
					end
				end
				default: begin
					link <= LINK_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Registers and diagnosis state
	// ****************************************
	logic [15:0] shreg;
	logic [4:0] cnt;
	logic frame_err;
	logic uv_flag;
	logic sent_diag;
	logic [CH-1:0] en;
	logic [CH-1:0] map0;
	logic [CH-1:0] map1;
	logic [CH-1:0] iol;
	logic openload_global_disable;
	logic [CH-1:0] osm;
	logic [CH-1:0] fault;
	logic uv_evt;
	logic [15:0] last_frame;
	spd_resp_e resp_sel;
	logic [3:0] resp_a0;
	logic [1:0] resp_a1;
	spd_frame_s frm;
	spd_diag_s diag_word;
	logic [15:0] resp_word;
	logic good;
	logic cmd_diag;
	logic do_write;
	logic do_read;
	logic soft_rst;
	logic regs_rst;

	// Addresses that exist; the status monitor is read only
	function automatic logic addr_ok(input logic [3:0] a0, input logic [1:0] a1,
			input logic wr);
		addr_ok = 1'b0;
		case (a0)
			A0_OUT, A0_DIAGCFG, A0_RST: addr_ok = (a1 == A1_ZERO);
			A0_MAP: addr_ok = (a1 == A1_ZERO) || (a1 == A1_MAP1);
			A0_OSM: addr_ok = (a1 == A1_ZERO) && !wr;
			default: addr_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] reg_read(input logic [3:0] a0, input logic [1:0] a1,
			input logic [CH-1:0] live_osm);
		reg_read = 8'h00;
		case (a0)
			A0_OUT: reg_read = {4'h0, en};
			A0_MAP: reg_read = {4'h0, (a1 == A1_MAP1) ? map1 : map0};
			A0_DIAGCFG: reg_read = {3'h0, openload_global_disable, iol};
			A0_OSM: reg_read = {4'h0, live_osm};
			default: reg_read = 8'h00;
		endcase
	endfunction

	always_comb begin
		frm = spd_frame_s'(shreg);
		good = (cnt == CNT_FULL);
		cmd_diag = ~frm.cmd[1] && (frm.data[1:0] == DIAG_TAIL);
		// Other codes and unmapped addresses fall through as syntax errors
		do_write = cs_rise && good && (frm.cmd == CMD_WRITE)
			&& addr_ok(frm.primary_addr_field, frm.secondary_addr_field, 1'b1);
		do_read = cs_rise && good && !cmd_diag && (frm.cmd == CMD_READ)
			&& addr_ok(frm.primary_addr_field, frm.secondary_addr_field, 1'b0);
		soft_rst = do_write && (frm.primary_addr_field == A0_RST) && frm.data[RST_BIT];
		regs_rst = rst || !sleep_n_s || soft_rst;
	end

	always_comb begin
		diag_word = spd_diag_s'(DIAG_RESET);
		diag_word.supply_undervolt_flag = uv_flag;
		diag_word.mode = (|en) ? MODE_ACTIVE : MODE_IDLE;
		diag_word.frame_error_flag = frame_err;
		diag_word.off_openload_flag = |(osm & ~out_on & openload_current_enable);
		diag_word.channel_fault_flag = fault;
		// Special frames and unmapped reads both answer with the diagnosis word
		if (resp_sel == RESP_REG) begin
			resp_word = {READ_ANS, resp_a0, resp_a1, reg_read(resp_a0, resp_a1, vds_s)};
		end else begin
			resp_word = diag_word;
		end
	end

	// Answer chosen at the end of one frame goes out in the next
	always_ff @(posedge sys_clk) begin
		if (regs_rst) begin
			resp_sel <= RESP_DIAG;
			resp_a0 <= 4'h0;
			resp_a1 <= 2'h0;
		end else if (cs_rise) begin
			resp_sel <= do_read ? RESP_REG : RESP_DIAG;
			resp_a0 <= frm.primary_addr_field;
			resp_a1 <= frm.secondary_addr_field;
		end
	end

	// Load on select fall, shift on falling serial clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shreg <= 16'h0000;
		end else if (cs_fall && sleep_n_s) begin
			shreg <= resp_word;
		end else if (sck_fall) begin
			shreg <= {shreg[14:0], sdi_s};
		end
	end

	// Wraps 23 back to 16 so chains of any length keep the modulo check
	always_ff @(posedge sys_clk) begin
		if (rst || cs_fall) begin
			cnt <= 5'h00;
		end else if (sck_fall) begin
			cnt <= (cnt == CNT_WRAP) ? CNT_FULL : cnt + 5'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sdo_out <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (cs_fall && sleep_n_s) begin
			sdo_oe <= 1'b1;
			sdo_out <= frame_err | sdi_s;
		end else if (csn_s || !sleep_n_s) begin
			sdo_oe <= 1'b0;
		end else if (sck_rise) begin
			sdo_out <= shreg[15];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (regs_rst) begin
			frame_err <= 1'b1;
		end else if (cs_rise) begin
			frame_err <= ~good;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sent_diag <= 1'b0;
		end else if (cs_fall && sleep_n_s) begin
			sent_diag <= (resp_sel == RESP_DIAG);
		end
	end

	// A new undervoltage event wins over the clear by a diagnosis readout
	always_ff @(posedge sys_clk) begin
		if (rst || !sleep_n_s) begin
			uv_flag <= 1'b1;
		end else if (uv_evt) begin
			uv_flag <= 1'b1;
		end else if (soft_rst || (cs_rise && good && sent_diag)) begin
			uv_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (regs_rst) begin
			en <= OUT_RST;
			map0 <= MAP0_RST;
			map1 <= MAP1_RST;
			iol <= 4'h0;
			openload_global_disable <= 1'b0;
		end else if (do_write) begin
			case (frm.primary_addr_field)
				A0_OUT: en <= frm.data[3:0];
				A0_MAP: begin
					if (frm.secondary_addr_field == A1_MAP1) begin
						map1 <= frm.data[3:0];
					end else begin
						map0 <= frm.data[3:0];
					end
				end
				A0_DIAGCFG: begin
					iol <= frm.data[3:0];
					openload_global_disable <= frm.data[OPENLOAD_GLOBAL_DISABLE_BIT];
				end
				default: en <= en;
			endcase
		end
	end

	// Status monitor refreshed whenever a serial read answer sends its contents out; AXI status reads leave it as it is
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			osm <= 4'h0;
		end else if (cs_fall && sleep_n_s && resp_sel == RESP_REG && resp_a0 == A0_OSM) begin
			osm <= vds_s;
		end
	end

	// ****************************************
	// Channel outputs
	// ****************************************
	// No open load term here: a detected open load never turns a channel off
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_on <= 4'h0;
			openload_current_enable <= 4'h0;
		end else begin
			out_on <= en | (map0 & {CH{in_s[0]}}) | (map1 & {CH{in_s[1]}});
			openload_current_enable <= iol & ~{CH{openload_global_disable}};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_frame <= 16'h0000;
		end else if (cs_rise && good) begin
			last_frame <= shreg;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (!s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == AXI_FAULT) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign uv_evt = s_axi_awready && s_axi_awaddr == AXI_FAULT && s_axi_wstrb[0]
		&& s_axi_wdata[FAULT_UV_BIT];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault <= 4'h0;
		end else if (s_axi_awready && s_axi_awaddr == AXI_FAULT && s_axi_wstrb[0]) begin
			fault <= s_axi_wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= AXI_OKAY;
				case (s_axi_araddr)
					AXI_STATUS: s_axi_rdata <= {8'h00, osm, out_on, 16'(diag_word)};
					AXI_FAULT: s_axi_rdata <= {28'h0000000, fault};
					AXI_LAST: s_axi_rdata <= {16'h0000, last_frame};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence seq_sel_fall;
		cs_fall && sleep_n_s;
	endsequence

	sequence seq_bad_end;
		cs_rise && (cnt != CNT_FULL);
	endsequence

	a_sdo_release: assert property ($rose(csn_s) |=> !sdo_oe)
		else $error("serial output still driven after deselect");
	a_sleep_quiet: assert property (cs_fall && !sleep_n_s |=> !sdo_oe && link == LINK_IDLE)
		else $error("transfer started during sleep");
	a_first_bit: assert property (seq_sel_fall |=> sdo_oe && sdo_out == $past(frame_err | sdi_s))
		else $error("first output bit is not error OR input");
	a_shift_out: assert property (sck_rise && !csn_s |=> sdo_out == $past(shreg[15]))
		else $error("output bit does not follow shift register");
	a_bad_len: assert property (seq_bad_end ##1 1 |-> frame_err && $stable(en))
		else $error("bad length frame not flagged or acted on");
	a_cnt_range: assert property (sck_fall && cnt == CNT_WRAP |=> cnt == CNT_FULL)
		else $error("pulse counter did not wrap to sixteen");
	a_write_out: assert property (do_write && frm.primary_addr_field == A0_OUT && !soft_rst
		|=> en == $past(frm.data[3:0]))
		else $error("write frame did not reach output control");
	a_read_next: assert property (seq_sel_fall ##0 (resp_sel == RESP_REG)
		|=> shreg[15:14] == READ_ANS)
		else $error("read answer missing in next frame");
	a_read_mark: assert property (do_read && sleep_n_s |=> resp_sel == RESP_REG)
		else $error("read not queued for next frame");
	a_disable_all: assert property (openload_global_disable [*2] |-> openload_current_enable == 4'h0)
		else $error("diagnosis current on while globally disabled");
	a_reset_ter: assert property ($fell(rst) |-> frame_err)
		else $error("error flag not set after reset");
endmodule
`default_nettype wire

// ==== bench/spd_ctrl.sv ====
// Controller model for the serial port: drives select, clock and data, reads back.
// Assumes sys_clk from the bench; one serial clock level lasts 4 sys_clk (80 ns).
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl (
	input wire logic sys_clk, // System clock
	input wire logic sdo_out, // Device data level
	input wire logic sdo_oe, // Device drive enable
	output logic select_low_pin = 1'b1, // Select, low active
	output logic sclk_pin = 1'b0, // Serial clock
	output logic sdi_pin = 1'b0 // Data to device
);
	logic last = 1'b0;
	logic line;

	// A released line toggles so that a stale level never reads as data
	assign line = sdo_oe ? sdo_out : ~last;

	always @(posedge sys_clk) begin
		last <= line;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Clock rests low across both select edges
	// Lead is the level shown between select fall and the first clock rise
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx,
			output logic lead);
		rx = '0;
		tick(1);
		select_low_pin <= 1'b0;
		tick(8);
		lead = line;
		for (int k = 0; k < n; k++) begin
			tick(2);
			sdi_pin <= tx[n-1-k];
			tick(2);
			sclk_pin <= 1'b1;
			tick(4);
			// Taken at the end of the high phase, after the rising edge moved it
			rx = {rx[30:0], line};
			sclk_pin <= 1'b0;
		end
		tick(4);
		select_low_pin <= 1'b1;
		sdi_pin <= 1'b0;
		tick(8);
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_spd_port.sv ====
// Self-checking bench for the serial diagnosis port and its AXI4-Lite side.
// Assumes spd_pkg, spd_port and the controller model spd_ctrl are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_spd_port;
	import spd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sleep_n_pin = 1'b1;
	logic [3:0] vds_low_pin = 4'h0;
	logic [1:0] in_pin = 2'h0;
	logic select_low_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe;
	logic [3:0] out_on, openload_current_enable;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int failures = 0;
	int compares = 0;

	always #10 sys_clk = ~sys_clk;

	spd_port i_spd_port (.sys_clk, .rst, .select_low_pin, .sclk_pin, .sdi_pin, .sdo_out,
		.sdo_oe, .sleep_n_pin, .vds_low_pin, .in_pin, .out_on, .openload_current_enable,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	spd_ctrl i_spd_ctrl (.sys_clk, .sdo_out, .sdo_oe, .select_low_pin, .sclk_pin, .sdi_pin);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic wrap_up;
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bound(input int n);
		if (n >= 50) begin
			failures++;
			wrap_up();
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		bound(n);
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		bound(n);
	endtask

	// Sends one frame and compares the answer left by the frame before
	task automatic ask(input logic [15:0] tx, input logic [15:0] exp);
		logic [31:0] r;
		logic lead;
		i_spd_ctrl.xfer(16, {16'h0, tx}, r, lead);
		check("answer", r, {16'h0, exp});
		if (!exp[15]) check("lead bit", lead, exp[10]);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		check("idle oe", sdo_oe, 1'b0);
		ask(16'h0001, 16'h5c00);
		ask(16'h0001, 16'h1800);
	endtask

	task automatic t_write_read;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(AXI_FAULT, 32'h3, r);
		check("fault resp", r, AXI_OKAY);
		ask(16'h8005, 16'h1803);
		check("out_on", out_on, 4'h5);
		ask(16'h4000, 16'h1003);
		ask(16'h0001, 16'h8005);
		axi_rd(AXI_STATUS, d, r);
		check("status out", d[19:16], 4'h5);
	endtask

	task automatic t_length;
		logic [31:0] r;
		logic lead;
		i_spd_ctrl.xfer(17, 32'h3, r, lead);
		check("odd frame", r[16:1], 16'h1003);
		i_spd_ctrl.xfer(24, 32'ha50001, r, lead);
		check("error answer", r[23:8], 16'h1403);
		check("error lead", lead, 1'b1);
		check("passed bits", r[7:0], 8'ha5);
		ask(16'h0001, 16'h1003);
	endtask

	task automatic t_syntax;
		ask(16'hc000, 16'h1003);
		check("out_on kept", out_on, 4'h5);
		ask(16'h7c00, 16'h1003);
		ask(16'h0001, 16'h1003);
	endtask

	task automatic t_openload;
		@(posedge sys_clk);
		vds_low_pin <= 4'h2;
		ask(16'h880f, 16'h1003);
		check("current on", openload_current_enable, 4'hf);
		tick(20); // Settling wait before the status read
		ask(16'h4c00, 16'h1003);
		ask(16'h0001, 16'h8c02);
		@(posedge sys_clk);
		vds_low_pin <= 4'h1;
		tick(20);
		ask(16'h881f, 16'h1103);
		check("current off", openload_current_enable, 4'h0);
	endtask

	task automatic t_inputs;
		@(posedge sys_clk);
		in_pin <= 2'h2;
		tick(10);
		check("mapped in", out_on, 4'hd);
		in_pin <= 2'h0;
		tick(10);
	endtask

	task automatic t_sleep;
		logic [31:0] r;
		int hits;
		logic lead;
		hits = 0;
		@(posedge sys_clk);
		sleep_n_pin <= 1'b0;
		tick(6);
		fork
			i_spd_ctrl.xfer(16, 32'h8003, r, lead);
			repeat (150) begin
				@(posedge sys_clk);
				if (sdo_oe !== 1'b0) hits++;
			end
		join
		check("sleep oe", hits, 0);
		sleep_n_pin <= 1'b1;
		tick(6);
		ask(16'h0001, 16'h5c03);
		check("sleep out", out_on, 4'h0);
	endtask

	task automatic t_swreset;
		ask(16'h8003, 16'h1803);
		check("out_on", out_on, 4'h3);
		ask(16'h9001, 16'h1003);
		check("reset out", out_on, 4'h0);
		ask(16'h0001, 16'h1c03);
	endtask

	task automatic t_axi;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(4'hc, d, r);
		check("unmapped resp", r, AXI_SLVERR);
		check("unmapped data", d, 32'h0);
		axi_wr(AXI_STATUS, 32'h0, r);
		check("ro write", r, AXI_SLVERR);
		axi_rd(AXI_FAULT, d, r);
		check("fault read", d, 32'h3);
		axi_rd(AXI_LAST, d, r);
		check("last frame", d, 32'h1);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		tick(4);
		t_reset();
		t_write_read();
		t_length();
		t_syntax();
		t_openload();
		t_inputs();
		t_sleep();
		t_swreset();
		t_axi();
		wrap_up();
	end
endmodule
`default_nettype wire
